// ===== rtl/ppgtm_top.sv
// Trigger and mode control of a four-group pulse pattern generator.
// Assumes timer strobes and the bus master are on ref_clk.
//
// Summary of operation
// [R01] The low next-data nibble register reads ones in bits 7:4, ignoring writes.
// [R02] Next-data bits 3:0 go to output-data bits 3:0 on group 0's trigger.
// [R03] Select code 00/01/10/11 picks timer channel 0/1/2/3 as trigger.
// [R04] Select fields sit at 7:6, 5:4, 3:2, 1:0 for groups 3..0, reset ones.
// [R05] An inversion bit of zero inverts the pins, one drives them direct.
// [R06] Inverted pins are low for data one and high for data zero.
// [R07] Inversion bits of groups 3..0 sit at mode bits 7..4, reset one.
// [R08] In normal mode a group updates only on match A of its channel.
// [R09] In non-overlap mode a group updates on match A or match B.
// [R10] Non-overlap bits of groups 3..0 sit at mode bits 3..0, reset zero.
// [R11] A non-overlap bit of one selects non-overlapping output.
// [R12] Non-overlap: match A copies all bits, match B copies only zeros.
// [R13] Transfers touch enabled bits only; writes to enabled bits are blocked.
// [R14] Each strobe is one clock and gives at most one transfer per group.
// [R15] The timer gives match A and B of each channel as separate strobes.
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module ppgtm_top
   import ppgtm_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Avalon-MM slave
   input wire ppgtm_avreq_s avReq,
   output logic [DW-1:0] avReadData,
   output logic avWaitRequest,
   // Timer compare-match strobes
   input wire ppgtm_timer_s timerMatch,
   // Pulse pins
   output logic [NBIT-1:0] pulseOut,
   output logic [NBIT-1:0] pulseOutEn
);

   ////////////////////////////////////////////////////////////////////////
   // Registers and bus state
   logic [NBIT-1:0] ndReg;
   logic [NBIT-1:0] oenReg;
   logic [NBIT-1:0] outReg;
   logic [NBIT-1:0] outNext;
   logic [NBIT-1:0] pulseReg;
   logic [NBIT-1:0] pulseNext;
   logic [7:0] trigReg;
   logic [7:0] modeReg;
   logic waitReg;
   logic [DW-1:0] rdReg;
   logic [DW-1:0] rdNext;
   logic [DW-1:0] wMask;
   logic [AW-1:0] wordAddr;
   logic wrAcc;
   logic wrNdLow;
   logic wrNd;
   logic wrTrig;
   logic wrMode;
   logic wrOen;
   logic wrOut;
   logic [NGRP-1:0] trigA;
   logic [NGRP-1:0] trigB;

   assign avReadData = rdReg;
   assign avWaitRequest = waitReg;
   assign pulseOut = pulseReg;
   assign pulseOutEn = oenReg;

   ////////////////////////////////////////////////////////////////////////
   // Bus handshake: one wait cycle, then a single-cycle answer
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         waitReg <= 1'b1;
      end else if (!waitReg) begin
         waitReg <= 1'b1;
      end else if (avReq.read || avReq.write) begin
         waitReg <= 1'b0;
      end
   end

   // Write strobes, taken only at the edge where waitrequest is low
   always_comb begin
      wordAddr = {avReq.address[AW-1:2], OFF_LANE};
      wrAcc = avReq.write && !waitReg;
      wrNdLow = 1'b0;
      wrNd = 1'b0;
      wrTrig = 1'b0;
      wrMode = 1'b0;
      wrOen = 1'b0;
      wrOut = 1'b0;
      if (wordAddr == OFF_ND_LOW) begin
         wrNdLow = wrAcc;
      end else if (wordAddr == OFF_ND) begin
         wrNd = wrAcc;
      end else if (wordAddr == OFF_TRIG) begin
         wrTrig = wrAcc;
      end else if (wordAddr == OFF_MODE) begin
         wrMode = wrAcc;
      end else if (wordAddr == OFF_OEN) begin
         wrOen = wrAcc;
      end else if (wordAddr == OFF_OUT) begin
         wrOut = wrAcc;
      end
   end

   // Byte lanes expand to a bit mask
   genvar b;
   generate
      for (b = 0; b < BE_W; b = b + 1) begin : g_lane
         assign wMask[b*BYTE_W +: BYTE_W] = {BYTE_W{avReq.byteenable[b]}};
      end
   endgenerate

   // Read mux; unmapped offsets read zero
   always_comb begin
      rdNext = RD_ZERO;
      if (wordAddr == OFF_ND_LOW) begin
         // [R01] upper nibble reads ones
         rdNext[7:0] = {LOW_FILL, ndReg[GW-1:0]};
      end else if (wordAddr == OFF_ND) begin
         rdNext[NBIT-1:0] = ndReg;
      end else if (wordAddr == OFF_TRIG) begin
         rdNext[7:0] = trigReg;
      end else if (wordAddr == OFF_MODE) begin
         rdNext[7:0] = modeReg;
      end else if (wordAddr == OFF_OEN) begin
         rdNext[NBIT-1:0] = oenReg;
      end else if (wordAddr == OFF_OUT) begin
         rdNext[NBIT-1:0] = outReg;
      end
   end

   // Read data latched as the wait cycle ends, stable while answered
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdReg <= RD_ZERO;
      end else if (waitReg && avReq.read) begin
         rdReg <= rdNext;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Next-data register, reachable whole or as the low nibble
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ndReg <= ND_RST;
      end else if (wrNd) begin
         ndReg <= (ndReg & ~wMask[NBIT-1:0])
                | (avReq.writedata[NBIT-1:0] & wMask[NBIT-1:0]);
      end else if (wrNdLow && avReq.byteenable[0]) begin
         // [R01] only bits 3:0 take the write
         ndReg[GW-1:0] <= avReq.writedata[GW-1:0];
      end
   end

   // Trigger select and mode registers
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         // [R04] all select bits reset to one
         trigReg <= TRIG_RST;
         // [R07] [R10] inversion ones, non-overlap zeros
         modeReg <= MODE_RST;
      end else begin
         if (wrTrig && avReq.byteenable[0]) begin
            trigReg <= avReq.writedata[7:0];
         end
         if (wrMode && avReq.byteenable[0]) begin
            modeReg <= avReq.writedata[7:0];
         end
      end
   end

   // Output enable register
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         oenReg <= OEN_RST;
      end else if (wrOen) begin
         oenReg <= (oenReg & ~wMask[NBIT-1:0])
                 | (avReq.writedata[NBIT-1:0] & wMask[NBIT-1:0]);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-group trigger: channel picked by the two-bit select field
   genvar g;
   generate
      for (g = 0; g < NGRP; g = g + 1) begin : g_grp
         logic [SEL_W-1:0] sel;
         // [R04] group g's field at bits 2g+1:2g
         assign sel = trigReg[g*SEL_W +: SEL_W];
         // [R03] code is the channel number
         // [R08] [R14] match A always fires once per strobe
         assign trigA[g] = timerMatch.matchA[sel];
         // [R09] [R11] match B only in non-overlap mode
         assign trigB[g] = timerMatch.matchB[sel]
                         && modeReg[NOV_LSB + g];
      end
   endgenerate

   // Per-bit output data update and pin polarity
   genvar i;
   generate
      for (i = 0; i < NBIT; i = i + 1) begin : g_bit
         always_comb begin
            // [R13] transfers only for enabled bits
            if (oenReg[i] && trigA[i/GW]) begin
               // [R02] [R12] match A copies the bit
               outNext[i] = ndReg[i];
            end else if (oenReg[i] && trigB[i/GW] && !ndReg[i]) begin
               // [R12] match B copies zeros only
               outNext[i] = 1'b0;
            end else if (wrOut && !oenReg[i] && wMask[i]) begin
               // [R13] processor writes reach disabled bits only
               outNext[i] = avReq.writedata[i];
            end else begin
               outNext[i] = outReg[i];
            end
            // [R05] [R06] clear inversion bit flips the pin
            pulseNext[i] = outNext[i] ^ ~modeReg[INV_LSB + i/GW];
         end
      end
   endgenerate

   // Output data and pins, registered together so pins never glitch
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         outReg <= OUT_RST;
         pulseReg <= OUT_RST ^ ~{{GW{MODE_RST[7]}}, {GW{MODE_RST[6]}},
                                 {GW{MODE_RST[5]}}, {GW{MODE_RST[4]}}};
      end else begin
         outReg <= outNext;
         pulseReg <= pulseNext;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   sequence s_rd_low;
      avReq.read && waitReg && (wordAddr == OFF_ND_LOW);
   endsequence

   sequence s_grp0_a;
      oenReg[0] && timerMatch.matchA[trigReg[1:0]];
   endsequence

   sequence s_grp0_b_only;
      oenReg[0] && modeReg[0] && timerMatch.matchB[trigReg[1:0]]
         && !timerMatch.matchA[trigReg[1:0]];
   endsequence

   a_low_nibble_fill: assert property ( // [R01]
      s_rd_low ##1 !waitReg |-> avReadData[7:4] == LOW_FILL)
      else $error("low nibble upper bits not ones");

   a_grp0_copy: assert property ( // [R02]
      s_grp0_a |=> outReg[0] == $past(ndReg[0]))
      else $error("group 0 match A did not copy");

   a_chan2_select: assert property ( // [R03]
      trigReg[7:6] == 2'h2 && oenReg[12] && timerMatch.matchA[2]
      |=> outReg[12] == $past(ndReg[12]))
      else $error("group 3 channel 2 trigger missed");

   a_invert_pin: assert property ( // [R06]
      !$past(modeReg[4]) |-> pulseOut[0] != outReg[0])
      else $error("inverted pin not inverted");

   a_direct_pin: assert property ( // [R05]
      $past(modeReg[7]) |-> pulseOut[15] == outReg[15])
      else $error("direct pin not direct");

   a_normal_hold: assert property ( // [R08]
      oenReg[GW-1:0] == 4'hf && !modeReg[0]
      && !timerMatch.matchA[trigReg[1:0]]
      |=> $stable(outReg[GW-1:0]))
      else $error("normal group changed without match A");

   a_nonov_zeros: assert property ( // [R12]
      s_grp0_b_only |=> outReg[0] == ($past(outReg[0]) & $past(ndReg[0])))
      else $error("match B transfer wrong");

   a_write_block: assert property ( // [R13]
      oenReg[1] && !trigA[0] && !trigB[0] |=> $stable(outReg[1]))
      else $error("enabled bit changed without trigger");

   a_wait_pulse: assert property (
      !waitReg |=> waitReg)
      else $error("waitrequest low over two cycles");

   // Bus answer: every request sees exactly one wait cycle
   a_wait_answer: assert property (
      (avReq.read || avReq.write) && waitReg |=> !waitReg)
      else $error("request not answered after one wait cycle");

   // Low nibble write must leave the upper next-data bits alone
   sequence s_wr_low;
      avReq.write && !waitReg && (wordAddr == OFF_ND_LOW);
   endsequence

   a_low_nibble_keep: assert property ( // [R01]
      s_wr_low |=> $stable(ndReg[NBIT-1:GW]))
      else $error("low nibble write reached upper next data");

   a_grp1_field: assert property ( // [R04]
      oenReg[4] && timerMatch.matchA[trigReg[3:2]]
      |=> outReg[4] == $past(ndReg[4]))
      else $error("group 1 select field not honoured");

   a_grp2_pin: assert property ( // [R07]
      pulseOut[8] == (outReg[8] ^ !$past(modeReg[6])))
      else $error("group 2 pin polarity wrong");

   a_normal_no_b: assert property ( // [R08]
      oenReg[8] && !modeReg[2] && !timerMatch.matchA[trigReg[5:4]]
      |=> $stable(outReg[8]))
      else $error("normal group 2 changed without match A");

   a_nonov_b_zero: assert property ( // [R09]
      oenReg[5] && modeReg[1] && !ndReg[5]
      && timerMatch.matchB[trigReg[3:2]]
      |=> !outReg[5])
      else $error("group 1 match B did not clear bit");

   a_grp3_nonov: assert property ( // [R10] [R11]
      oenReg[15] && modeReg[3] && !timerMatch.matchA[trigReg[7:6]]
      && timerMatch.matchB[trigReg[7:6]]
      |=> outReg[15] == ($past(outReg[15]) & $past(ndReg[15])))
      else $error("group 3 match B transfer wrong");

   a_free_write: assert property ( // [R13]
      avReq.write && !waitReg && (wordAddr == OFF_OUT)
      && avReq.byteenable[1] && !oenReg[8]
      |=> outReg[8] == $past(avReq.writedata[8]))
      else $error("write to disabled output bit lost");

   // A strobe held for one clock must not transfer twice
   sequence s_grp0_quiet;
      oenReg[0] && !timerMatch.matchA[trigReg[1:0]]
         && !(modeReg[0] && timerMatch.matchB[trigReg[1:0]]);
   endsequence

   a_one_transfer: assert property ( // [R14]
      s_grp0_a ##1 s_grp0_quiet |=> $stable(outReg[0]))
      else $error("group 0 transferred without a strobe");

endmodule

`default_nettype wire

// ===== rtl/ppgtm_pkg.sv
// Constants and carrier types of the pulse pattern trigger and mode block.
// Assumes a 32-bit Avalon-MM slave port and four timer channels.
package ppgtm_pkg;
   // Group and bit counts
   localparam int NGRP = 4;
   localparam int GW = 4;
   localparam int NBIT = 16;
   localparam int NCH = 4;
   localparam int SEL_W = 2;
   localparam int AW = 5;
   localparam int DW = 32;
   localparam int BE_W = 4;
   localparam int BYTE_W = 8;
   localparam int INV_LSB = 4;
   localparam int NOV_LSB = 0;
   localparam int LOW_FILL_LSB = 4;

   // Register byte offsets
   localparam logic [AW-1:0] OFF_ND_LOW = 5'h00;
   localparam logic [AW-1:0] OFF_ND = 5'h04;
   localparam logic [AW-1:0] OFF_TRIG = 5'h08;
   localparam logic [AW-1:0] OFF_MODE = 5'h0c;
   localparam logic [AW-1:0] OFF_OEN = 5'h10;
   localparam logic [AW-1:0] OFF_OUT = 5'h14;
   localparam logic [1:0] OFF_LANE = 2'h0;

   // Reset values
   localparam logic [NBIT-1:0] ND_RST = 16'h0000;
   localparam logic [NBIT-1:0] OEN_RST = 16'h0000;
   localparam logic [NBIT-1:0] OUT_RST = 16'h0000;
   localparam logic [7:0] TRIG_RST = 8'hff;
   localparam logic [7:0] MODE_RST = 8'hf0;
   localparam logic [3:0] LOW_FILL = 4'hf;
   localparam logic [DW-1:0] RD_ZERO = 32'h0000_0000;

   // Compare-match strobes of the four timer channels
   typedef struct packed {
      logic [NCH-1:0] matchA;
      logic [NCH-1:0] matchB;
   } ppgtm_timer_s;

   // Avalon-MM request from the master
   typedef struct packed {
      logic [AW-1:0] address;
      logic read;
      logic write;
      logic [DW-1:0] writedata;
      logic [BE_W-1:0] byteenable;
   } ppgtm_avreq_s;
endpackage

// ===== bench/ppgtm_timer_model.sv
// Behavioural timer unit facing the pulse pattern trigger block.
// Assumes the caller invokes strobe right after a rising ref_clk edge.
`timescale 1ns/1ps
`default_nettype none

module ppgtm_timer_model
   import ppgtm_pkg::*;
(
   // Clock
   input wire logic ref_clk,
   // Compare-match strobes
   output var ppgtm_timer_s timerMatch
);
   // Strobes idle low so no stray transfer happens after reset
   initial timerMatch = '0;

   ////////////////////////////////////////////////////////////////////////
   // separate one-clock strobes
   // A then B may share a cycle; the block resolves that case itself
   task automatic strobe(input logic [NCH-1:0] a, input logic [NCH-1:0] b);
      timerMatch <= '{matchA: a, matchB: b};
      @(posedge ref_clk);
      timerMatch <= '0;
      @(posedge ref_clk);
   endtask
endmodule

`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench of the pulse pattern trigger and mode block.
// Assumes the block answers each access within twenty clock cycles.
`timescale 1ns/1ps
`default_nettype none

module tb;
   import ppgtm_pkg::*;
   logic ref_clk, reset_n, avWaitRequest;
   ppgtm_avreq_s avReq;
   ppgtm_timer_s timerMatch;
   logic [DW-1:0] avReadData, rdVal;
   logic [NBIT-1:0] pulseOut, pulseOutEn, expOut, ndVal, oenVal, pinExp;
   logic [7:0] trigSel, modeReg;
   int errCount, checkCount;

   ppgtm_top ppgtm_top_inst (.ref_clk(ref_clk), .reset_n(reset_n),
      .avReq(avReq), .avReadData(avReadData),
      .avWaitRequest(avWaitRequest), .timerMatch(timerMatch),
      .pulseOut(pulseOut), .pulseOutEn(pulseOutEn));
   ppgtm_timer_model ppgtm_timer_model_inst (.ref_clk(ref_clk),
      .timerMatch(timerMatch));

   ////////////////////////////////////////////////////////////////////////
   // 125 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   task automatic giveVerdict();
      if (errCount == 0 && checkCount > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input string name, input logic [DW-1:0] seen, exp);
      checkCount++;
      if (seen !== exp) begin
         errCount++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One Avalon access; request held until waitrequest is sampled low
   task automatic acc(input logic wr, input logic [AW-1:0] a,
                      input logic [DW-1:0] d, output logic [DW-1:0] q);
      int n;
      n = 0;
      avReq <= '{a, ~wr, wr, d, 4'hf};
      do begin
         @(posedge ref_clk);
         n++;
      end while (avWaitRequest !== 1'b0 && n < 20);
      q = avReadData;
      avReq <= '0;
      @(posedge ref_clk);
      if (n >= 20) begin
         errCount++;
         $display("unexpected waitrequest expected 0 seen 1");
         giveVerdict();
      end
   endtask

   // Write and keep the bench's own view of the registers
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      logic [DW-1:0] q;
      acc(1'b1, a, d, q);
      case (a)
         OFF_ND_LOW: ndVal[3:0] = d[3:0];
         OFF_ND: ndVal = d[NBIT-1:0];
         OFF_TRIG: trigSel = d[7:0];
         OFF_MODE: modeReg = d[7:0];
         OFF_OEN: oenVal = d[NBIT-1:0];
         OFF_OUT: expOut = (oenVal & expOut) | (~oenVal & d[NBIT-1:0]);
         default: ;
      endcase
   endtask

   task automatic rdChk(input string name, input logic [AW-1:0] a,
                        input logic [DW-1:0] exp);
      logic [DW-1:0] q;
      acc(1'b0, a, RD_ZERO, q);
      chk(name, q, exp);
   endtask

   // Predict a strobe: A copies all, B in non-overlap copies zeros only
   task automatic fire(input logic [NCH-1:0] a, input logic [NCH-1:0] b);
      logic [1:0] ch;
      logic [3:0] src, en;
      for (int g = 0; g < NGRP; g++) begin
         ch = trigSel[2*g+:2];
         en = oenVal[4*g+:4];
         src = a[ch] ? ndVal[4*g+:4] : expOut[4*g+:4] & ndVal[4*g+:4];
         if (a[ch] || (modeReg[g] && b[ch]))
            expOut[4*g+:4] = (en & src) | (~en & expOut[4*g+:4]);
      end
      ppgtm_timer_model_inst.strobe(a, b);
   endtask

   // Output data, pins and pin enables against the prediction
   task automatic chkOut();
      for (int g = 0; g < NGRP; g++)
         pinExp[4*g+:4] = modeReg[INV_LSB+g] ? expOut[4*g+:4]
                                             : ~expOut[4*g+:4];
      rdChk("outData", OFF_OUT, {16'h0000, expOut});
      chk("pulseOut", {16'h0000, pulseOut}, {16'h0000, pinExp});
      chk("pulseOutEn", {16'h0000, pulseOutEn}, {16'h0000, oenVal});
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      logic [7:0] perm [5];
      perm[0] = 8'he4;
      perm[1] = 8'h1b;
      perm[2] = 8'h39;
      perm[3] = 8'h4e;
      perm[4] = 8'h93;
      errCount = 0;
      checkCount = 0;
      reset_n = 1'b0;
      avReq = '0;
      {expOut, ndVal, oenVal, trigSel, modeReg} = {48'h0, 8'hff, 8'hf0};
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'b1;
      rdChk("trigSel", OFF_TRIG, 32'h0000_00ff);
      rdChk("mode", OFF_MODE, 32'h0000_00f0);
      rdChk("ndLow", OFF_ND_LOW, 32'h0000_00f0);
      chkOut();
      wr(OFF_ND_LOW, 32'hffff_ff5a);
      rdChk("ndLow", OFF_ND_LOW, 32'h0000_00fa);
      rdChk("unmapped", 5'h18, RD_ZERO);
      wr(OFF_OEN, 32'h0000_ffff);
      wr(OFF_OUT, 32'h0000_1234);
      chkOut();
      // Every group meets every select code somewhere in the sweep
      for (int p = 0; p < 5; p++) begin
         wr(OFF_TRIG, {24'h0, perm[p]});
         fire(4'h0, 4'hf);
         chkOut();
         for (int ch = 0; ch < NCH; ch++) begin
            wr(OFF_ND, 32'h0000_1111 * (ch * 3 + p * 5 + 2));
            fire(4'h1 << ch, 4'h0);
            chkOut();
         end
      end
      wr(OFF_MODE, 32'h0000_00ff);
      wr(OFF_ND, 32'h0000_3c5a);
      fire(4'h0, 4'hf);
      chkOut();
      fire(4'hf, 4'h0);
      chkOut();
      wr(OFF_MODE, 32'h0000_00a0);
      chkOut();
      wr(OFF_OEN, 32'h0000_00ff);
      wr(OFF_OUT, 32'h0000_ffff);
      wr(OFF_ND, 32'h0000_0000);
      fire(4'hf, 4'h0);
      chkOut();
      giveVerdict();
   end
endmodule

`default_nettype wire
